// ==== hdl/nbu_pkg.sv ====
// nbu_pkg: constants and types shared by the nine-bit serial channel.
// assumes a 32-bit apb slave with word-aligned registers.
`default_nettype none

package nbu_pkg;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFF_MODE0 = 8'h00;   // serial_mode_reg0
    localparam logic [7:0] OFF_CTRL = 8'h04;    // serial_control_reg
    localparam logic [7:0] OFF_DATA = 8'h08;    // serial_data_buffer
    localparam logic [7:0] OFF_MODE2 = 8'h0C;   // serial_mode_reg2
    localparam logic [7:0] OFF_BAUD = 8'h10;    // clocks per bit
    localparam logic [7:0] OFF_ODS = 8'h14;     // open_drain_select_reg
    localparam logic [7:0] OFF_ISTAT = 8'h18;   // sticky events, read clears
    localparam logic [7:0] OFF_IMASK = 8'h1C;   // event mask
    localparam logic [7:0] OFF_SELCODE = 8'h20; // own selection code

    // =====================================================================
    // field positions
    localparam int MODE0_SM_LO = 0;      // channel_mode_select [1:0]
    localparam int MODE0_WU = 2;         // wakeup_enable
    localparam int MODE0_TB8 = 3;        // tx_ninth_bit
    localparam int MODE0_RXE = 4;        // receive enable
    localparam int CTRL_RB8 = 0;         // rx_ninth_bit, read only
    localparam int CTRL_PE = 1;          // parity_enable
    localparam int CTRL_BUSY = 2;        // transmitter busy, read only
    localparam int MODE2_STOP_LENGTH_SELECT = 0;      // stop_length_select: 0 one, 1 two
    localparam int ODS_TX = 0;           // serial_out_pin open drain
    localparam int SEL_AUTO = 8;         // hardware match clears wakeup
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;

    // =====================================================================
    // encodings and reset values
    localparam logic [1:0] SM_NINE_BIT = 2'h3;
    localparam logic [15:0] BAUD_RESET = 16'h0010;
    localparam logic [15:0] BAUD_MIN = 16'h0002;
    localparam logic [3:0] FRAME_BITS = 4'h9;   // eight data bits plus ninth

    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } nbu_frame_t;

    typedef enum logic [3:0] {
        NBU_IDLE = 4'h1,
        NBU_START = 4'h2,
        NBU_BITS = 4'h4,
        NBU_STOP = 4'h8
    } nbu_state_t;

endpackage : nbu_pkg

`default_nettype wire

// ==== hdl/nbu_uart.sv ====
// nbu_uart: nine-bit asynchronous serial channel with slave wake-up,
// reached over apb. assumes rx_in is already synchronous to pclk and
// that the board pulls the shared line high when nobody drives it low.
//
// Notes on behaviour
// - mode field 11 selects nine-bit operation
// - transmit ninth bit from tx_ninth_bit field
// - received ninth bit lands in rx_ninth_bit
// - stop bit count follows stop_length_select
// - wakeup_enable set enables slave wake-up
// - wake-up: interrupt only when ninth bit one
// - slave transmit pin used open drain
// - matching selection code clears wakeup_enable
// - waiting slaves ignore ninth-bit-zero payload
// - selected slave may transmit reply
// - interrupts on frame received, frame sent
//
// Implementation choices: the APB interface to the registers and the address map.
`default_nettype none

module nbu_uart (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_in,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic irq
);

    // =====================================================================
    // register state
    logic [1:0] channel_mode_select_reg;
    logic wakeup_enable_reg;
    logic tx_ninth_bit_reg;
    logic rx_enable_reg;
    logic parity_enable_reg;
    logic stop_length_select_reg;
    logic [15:0] baud_reg;
    logic open_drain_select_reg;
    logic [1:0] istat_reg;
    logic [1:0] imask_reg;
    logic [8:0] selcode_reg;
    nbu_pkg::nbu_frame_t rx_frame_reg;

    logic nine_bit_mode;
    logic bus_done;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [1:0] ev;
    logic tx_done;
    logic rx_done;
    logic rx_raise;
    logic rx_match;
    logic tx_busy;
    logic [1:0] istat_clr;

    // word offset decode, used by both read mux and write strobes
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction : hit

    // only the nine-bit mode is built; other mode codes leave the line idle
    assign nine_bit_mode = (channel_mode_select_reg == nbu_pkg::SM_NINE_BIT);

    // =====================================================================
    // apb slave: one wait state, pready straight from a flop
    assign bus_done = psel && penable && pready;
    assign wr_en = bus_done && pwrite;
    assign rd_en = bus_done && !pwrite;
    assign addr_ok = hit(paddr, nbu_pkg::OFF_MODE0) || hit(paddr, nbu_pkg::OFF_CTRL)
        || hit(paddr, nbu_pkg::OFF_DATA) || hit(paddr, nbu_pkg::OFF_MODE2)
        || hit(paddr, nbu_pkg::OFF_BAUD) || hit(paddr, nbu_pkg::OFF_ODS)
        || hit(paddr, nbu_pkg::OFF_ISTAT) || hit(paddr, nbu_pkg::OFF_IMASK)
        || hit(paddr, nbu_pkg::OFF_SELCODE);

    // pready rises in the second access cycle and drops right after the handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
        end
    end

    // read data is captured together with pready so it holds through the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && penable && !pready && !pwrite) begin
            prdata <= 32'h00000000;
            if (hit(paddr, nbu_pkg::OFF_MODE0)) begin
                prdata[4:0] <= {rx_enable_reg, tx_ninth_bit_reg, wakeup_enable_reg,
                    channel_mode_select_reg};
            end
            if (hit(paddr, nbu_pkg::OFF_CTRL)) begin
                prdata[2:0] <= {tx_busy, parity_enable_reg, rx_frame_reg.ninth};
            end
            if (hit(paddr, nbu_pkg::OFF_DATA)) begin
                prdata[7:0] <= rx_frame_reg.data;
            end
            if (hit(paddr, nbu_pkg::OFF_MODE2)) begin
                prdata[0] <= stop_length_select_reg;
            end
            if (hit(paddr, nbu_pkg::OFF_BAUD)) begin
                prdata[15:0] <= baud_reg;
            end
            if (hit(paddr, nbu_pkg::OFF_ODS)) begin
                prdata[0] <= open_drain_select_reg;
            end
            if (hit(paddr, nbu_pkg::OFF_ISTAT)) begin
                prdata[1:0] <= istat_reg;
            end
            if (hit(paddr, nbu_pkg::OFF_IMASK)) begin
                prdata[1:0] <= imask_reg;
            end
            if (hit(paddr, nbu_pkg::OFF_SELCODE)) begin
                prdata[8:0] <= selcode_reg;
            end
        end
    end

    // =====================================================================
    // mode 0: wakeup_enable is also cleared by a matching selection frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_mode_select_reg <= 2'h0;
            wakeup_enable_reg <= 1'b0;
            tx_ninth_bit_reg <= 1'b0;
            rx_enable_reg <= 1'b0;
        end else begin
            if (wr_en && hit(paddr, nbu_pkg::OFF_MODE0)) begin
                channel_mode_select_reg <= pwdata[nbu_pkg::MODE0_SM_LO +: 2];
                wakeup_enable_reg <= pwdata[nbu_pkg::MODE0_WU];
                tx_ninth_bit_reg <= pwdata[nbu_pkg::MODE0_TB8];
                rx_enable_reg <= pwdata[nbu_pkg::MODE0_RXE];
            end else if (rx_match) begin
                wakeup_enable_reg <= 1'b0;
            end
        end
    end

    // remaining plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            parity_enable_reg <= 1'b0;
            stop_length_select_reg <= 1'b0;
            baud_reg <= nbu_pkg::BAUD_RESET;
            open_drain_select_reg <= 1'b0;
            imask_reg <= 2'h0;
            selcode_reg <= 9'h000;
        end else if (wr_en) begin
            // parity bit is stored only; no parity is ever sent in this mode
            if (hit(paddr, nbu_pkg::OFF_CTRL)) begin
                parity_enable_reg <= pwdata[nbu_pkg::CTRL_PE];
            end
            if (hit(paddr, nbu_pkg::OFF_MODE2)) begin
                stop_length_select_reg <= pwdata[nbu_pkg::MODE2_STOP_LENGTH_SELECT];
            end
            // a divisor below two would leave no mid-bit sample point
            if (hit(paddr, nbu_pkg::OFF_BAUD)) begin
                baud_reg <= (pwdata[15:0] < nbu_pkg::BAUD_MIN) ? nbu_pkg::BAUD_MIN
                    : pwdata[15:0];
            end
            if (hit(paddr, nbu_pkg::OFF_ODS)) begin
                open_drain_select_reg <= pwdata[nbu_pkg::ODS_TX];
            end
            if (hit(paddr, nbu_pkg::OFF_IMASK)) begin
                imask_reg <= pwdata[1:0];
            end
            if (hit(paddr, nbu_pkg::OFF_SELCODE)) begin
                selcode_reg <= pwdata[8:0];
            end
        end
    end

    // =====================================================================
    // interrupt status: a read clears only the bits it returned, so an event
    // landing between the data capture and the handshake is not lost
    assign ev = {tx_done, rx_raise};
    assign istat_clr = (rd_en && hit(paddr, nbu_pkg::OFF_ISTAT)) ? prdata[1:0] : 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            istat_reg <= (istat_reg & ~istat_clr) | ev;
            irq <= |(((istat_reg & ~istat_clr) | ev) & imask_reg);
        end
    end

    // =====================================================================
    // transmitter: a data write launches one frame
    nbu_pkg::nbu_state_t tx_state_reg;
    logic [15:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic [8:0] tx_shift_reg;
    logic tx_tick;
    logic tx_line;

    assign tx_busy = (tx_state_reg != nbu_pkg::NBU_IDLE);
    assign tx_tick = (tx_cnt_reg == (baud_reg - 16'h0001));
    assign tx_done = (tx_state_reg == nbu_pkg::NBU_STOP) && tx_tick
        && (tx_bit_reg == {3'h0, stop_length_select_reg});

    // a write while busy is dropped; software waits for the transmit event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= nbu_pkg::NBU_IDLE;
            tx_cnt_reg <= 16'h0000;
            tx_bit_reg <= 4'h0;
            tx_shift_reg <= 9'h1FF;
        end else begin
            tx_cnt_reg <= (tx_busy && !tx_tick) ? tx_cnt_reg + 16'h0001 : 16'h0000;
            unique case (tx_state_reg)
                nbu_pkg::NBU_IDLE: begin
                    if (wr_en && hit(paddr, nbu_pkg::OFF_DATA) && nine_bit_mode) begin
                        tx_shift_reg <= {tx_ninth_bit_reg, pwdata[7:0]};
                        tx_bit_reg <= 4'h0;
                        tx_state_reg <= nbu_pkg::NBU_START;
                    end
                end
                nbu_pkg::NBU_START: begin
                    if (tx_tick) begin
                        tx_state_reg <= nbu_pkg::NBU_BITS;
                    end
                end
                nbu_pkg::NBU_BITS: begin
                    if (tx_tick) begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
                        if (tx_bit_reg == nbu_pkg::FRAME_BITS - 4'h1) begin
                            tx_bit_reg <= 4'h0;
                            tx_state_reg <= nbu_pkg::NBU_STOP;
                        end else begin
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                        end
                    end
                end
                nbu_pkg::NBU_STOP: begin
                    if (tx_done) begin
                        tx_state_reg <= nbu_pkg::NBU_IDLE;
                    end else if (tx_tick) begin
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                    end
                end
            endcase
        end
    end

    // line level; open drain only ever pulls low and releases for a high
    assign tx_line = (tx_state_reg == nbu_pkg::NBU_START) ? 1'b0
        : (tx_state_reg == nbu_pkg::NBU_BITS) ? tx_shift_reg[0] : 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin <= 1'b1;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_pin <= open_drain_select_reg ? 1'b0 : tx_line;
            serial_out_oe <= open_drain_select_reg ? !tx_line : 1'b1;
        end
    end

    // =====================================================================
    // receiver: samples each bit at its middle
    nbu_pkg::nbu_state_t rx_state_reg;
    logic [15:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [8:0] rx_shift_reg;
    logic rx_mid;

    assign rx_mid = (rx_cnt_reg == {1'b0, baud_reg[15:1]});
    assign rx_done = (rx_state_reg == nbu_pkg::NBU_STOP) && rx_mid;
    // with wake-up on, only frames whose ninth bit is one are passed up
    assign rx_raise = rx_done && rx_in && !(wakeup_enable_reg && !rx_shift_reg[8]);
    assign rx_match = rx_raise && wakeup_enable_reg && selcode_reg[nbu_pkg::SEL_AUTO]
        && (rx_shift_reg[7:0] == selcode_reg[7:0]);

    // a frame with a low stop bit is discarded; only one stop bit is checked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg <= nbu_pkg::NBU_IDLE;
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
        end else begin
            rx_cnt_reg <= (rx_state_reg == nbu_pkg::NBU_IDLE
                || rx_cnt_reg == baud_reg - 16'h0001) ? 16'h0000 : rx_cnt_reg + 16'h0001;
            unique case (rx_state_reg)
                nbu_pkg::NBU_IDLE: begin
                    if (!rx_in && rx_enable_reg && nine_bit_mode) begin
                        rx_state_reg <= nbu_pkg::NBU_START;
                    end
                end
                nbu_pkg::NBU_START: begin
                    if (rx_mid) begin
                        rx_bit_reg <= 4'h0;
                        rx_state_reg <= rx_in ? nbu_pkg::NBU_IDLE : nbu_pkg::NBU_BITS;
                    end
                end
                nbu_pkg::NBU_BITS: begin
                    if (rx_mid) begin
                        rx_shift_reg <= {rx_in, rx_shift_reg[8:1]};
                        if (rx_bit_reg == nbu_pkg::FRAME_BITS - 4'h1) begin
                            rx_state_reg <= nbu_pkg::NBU_STOP;
                        end else begin
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                        end
                    end
                end
                nbu_pkg::NBU_STOP: begin
                    if (rx_mid) begin
                        rx_state_reg <= nbu_pkg::NBU_IDLE;
                    end
                end
            endcase
        end
    end

    // buffer and ninth bit update only for frames that are passed up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_frame_reg <= '0;
        end else if (rx_raise) begin
            rx_frame_reg <= rx_shift_reg;
        end
    end

endmodule : nbu_uart

`default_nettype wire

// ==== tb/nbu_uart_checker.sv ====
// nbu_uart_checker: port-level assertions for nbu_uart.
// assumes mode, baud, stop length and mask change only by apb writes.
`default_nettype none

module nbu_uart_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_in,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    input wire logic irq
);
    // =====================================================================
    // shadow state rebuilt from completed writes
    logic [3:0] m0;
    logic m2;
    logic ods;
    logic [1:0] im;
    logic [15:0] bt;
    logic pend;
    logic act;
    logic lst;
    logic [11:0] sh;
    logic [15:0] cnt;
    logic [3:0] nb;
    wire logic acc = psel & penable & pready;
    wire logic wr = acc & pwrite;
    wire logic line = serial_out_oe ? serial_out_pin : 1'b1; // board pull-up
    wire logic go = wr && paddr[7:0] == nbu_pkg::OFF_DATA && !pend && !act
        && m0[1:0] == nbu_pkg::SM_NINE_BIT;
    wire logic tx_end = act && cnt == bt && nb == (lst ? 4'hB : 4'hA);

    // shadow registers; writes below two clocks per bit are raised to two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {m0, m2, ods, im, bt} <= {8'h00, 16'h0010};
        end else if (wr) begin
            case (paddr[7:0])
                nbu_pkg::OFF_MODE0: m0 <= pwdata[3:0];
                nbu_pkg::OFF_MODE2: m2 <= pwdata[0];
                nbu_pkg::OFF_ODS: ods <= pwdata[0];
                nbu_pkg::OFF_IMASK: im <= pwdata[1:0];
                nbu_pkg::OFF_BAUD: bt <= (pwdata[15:0] < 16'h0002) ? 16'h0002 : pwdata[15:0];
                default: ;
            endcase
        end
    end

    // reference frame, one bit per bit time, starting two cycles after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {pend, act, lst, sh, cnt, nb} <= '0;
        end else begin
            pend <= go;
            if (go) begin
                sh <= {2'b11, m0[nbu_pkg::MODE0_TB8], pwdata[7:0], 1'b0};
                lst <= m2;
            end
            if (pend) begin
                {act, cnt, nb} <= {1'b1, 16'h0001, 4'h0};
            end else if (act && cnt == bt) begin
                {cnt, nb, sh} <= {16'h0001, nb + 4'h1, 1'b1, sh[11:1]};
                if (nb == (lst ? 4'hB : 4'hA)) act <= 1'b0;
            end else if (act) begin
                cnt <= cnt + 16'h0001;
            end
        end
    end

    // =====================================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_tx_bits; act |-> line == sh[0]; endproperty
    property p_idle_high; !act |-> line; endproperty
    property p_od_low; $past(ods) |-> !(serial_out_oe && serial_out_pin); endproperty
    property p_pp_drive; !ods && !$past(ods) && $past(presetn) |-> serial_out_oe; endproperty
    property p_tx_irq; tx_end && im[1] |-> ##[1:4] irq; endproperty
    property p_rd_clear;
        acc && !pwrite && paddr[7:0] == nbu_pkg::OFF_ISTAT && !act && !pend |-> ##[1:2] !irq;
    endproperty
    property p_rdy_pulse; pready |=> !pready; endproperty
    property p_rdy_access; pready |-> psel && penable && $past(psel); endproperty
    property p_unmapped; pready && paddr[7:0] > 8'h20 |-> pslverr && prdata == 32'h0; endproperty
    a_tx_bits: assert property (p_tx_bits)
        else $error("serial line differs from the expected frame bit");
    a_idle_high: assert property (p_idle_high)
        else $error("serial line low outside a frame");
    a_od_low: assert property (p_od_low)
        else $error("open drain pin drives high");
    a_pp_drive: assert property (p_pp_drive)
        else $error("push pull pin not driven");
    a_tx_irq: assert property (p_tx_irq)
        else $error("no interrupt after frame sent");
    a_rd_clear: assert property (p_rd_clear)
        else $error("interrupt stays after status read");
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready longer than one cycle");
    a_rdy_access: assert property (p_rdy_access)
        else $error("ready outside an access phase");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access without error");
    c_tx_end: cover property (tx_end);
    c_irq: cover property ($rose(irq));
    c_err: cover property (pready && pslverr);
endmodule : nbu_uart_checker

bind nbu_uart nbu_uart_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .serial_out_pin(serial_out_pin),
    .serial_out_oe(serial_out_oe), .irq(irq));

`default_nettype wire

// ==== tb/nbu_link_model.sv ====
// nbu_link_model: the other controller on the shared link, sending
// frames to rx_in and decoding frames seen on the pulled-up line.
`default_nettype none

module nbu_link_model (
    input wire logic pclk,
    input wire logic line,
    output logic rx_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    int bt = 4;
    int n_got = 0;
    logic [8:0] got = 9'h000;
    initial rx_drv = 1'b1;

    // =====================================================================
    // start low, data lsb first, ninth bit, one high stop bit
    task automatic send(input logic [8:0] f);
        logic [10:0] w;
        w = {1'b1, f, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk);
            rx_drv <= w[i];
            repeat (bt - 1) @(posedge pclk);
        end
    endtask : send

    // sample mid-bit; a frame whose stop bit is low is dropped
    initial begin
        logic [8:0] f;
        forever begin
            @(posedge pclk);
            if (line === 1'b0) begin
                repeat (bt / 2) @(posedge pclk);
                for (int i = 0; i < 9; i++) begin
                    repeat (bt) @(posedge pclk);
                    f[i] = line;
                end
                repeat (bt) @(posedge pclk);
                if (line === 1'b1) begin
                    got = f;
                    n_got++;
                end
            end
        end
    end
endmodule : nbu_link_model

`default_nettype wire

// ==== tb/nbu_uart_tb.sv ====
// nbu_uart_tb: directed bench for nbu_uart over apb and the serial link.
// assumes nbu_link_model stands on the far side at four clocks per bit.
`default_nettype none

module nbu_uart_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, rx_in, pin, oe, irq, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    wire logic line = oe ? pin : 1'b1; // released line floats to the pull-up
    int mismatches = 0;
    int n_compared = 0;

    nbu_uart dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_in), .serial_out_pin(pin), .serial_out_oe(oe), .irq(irq));
    nbu_link_model link_u (.pclk(pclk), .line(line), .rx_drv(rx_in));

    // =====================================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // setup, access, then hold until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [32:0] r);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 24'h0, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r[31:0], e);
    endtask : rd

    task automatic wait_irq;
        for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
    endtask : wait_irq

    task automatic wait_got(input int n);
        for (int i = 0; i < 400 && link_u.n_got < n; i++) @(posedge pclk);
        chk(link_u.n_got, n);
    endtask : wait_got

    // =====================================================================
    // scenarios
    task automatic t_reset;
        logic [32:0] r;
        rd(nbu_pkg::OFF_MODE0, 32'h0);
        rd(nbu_pkg::OFF_BAUD, 32'h10);
        rd(nbu_pkg::OFF_CTRL, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r);
        chk(r[32:1], 32'h80000000);
        wr(nbu_pkg::OFF_DATA, 32'h12);
        repeat (40) @(posedge pclk);
        chk(link_u.n_got, 0);
        $display("reset test done");
    endtask : t_reset

    // second frame: two stops, tx interrupt masked
    task automatic t_tx;
        wr(nbu_pkg::OFF_BAUD, 32'h4);
        wr(nbu_pkg::OFF_IMASK, 32'h3);
        wr(nbu_pkg::OFF_MODE0, 32'hB);
        wr(nbu_pkg::OFF_DATA, 32'h55);
        wait_got(1);
        chk({23'h0, link_u.got}, 32'h155);
        wait_irq();
        rd(nbu_pkg::OFF_ISTAT, 32'h2);
        rd(nbu_pkg::OFF_ISTAT, 32'h0);
        wr(nbu_pkg::OFF_IMASK, 32'h1);
        wr(nbu_pkg::OFF_MODE2, 32'h1);
        wr(nbu_pkg::OFF_MODE0, 32'h3);
        wr(nbu_pkg::OFF_DATA, 32'hA3);
        wait_got(2);
        chk({23'h0, link_u.got}, 32'h0A3);
        repeat (30) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(nbu_pkg::OFF_ISTAT, 32'h2);
        wr(nbu_pkg::OFF_IMASK, 32'h3);
        $display("transmit test done");
    endtask : t_tx

    task automatic t_wake;
        logic [8:0] fr [3] = '{9'h133, 9'h15A, 9'h099};
        logic [31:0] mw [3] = '{32'h17, 32'h13, 32'h13};
        wr(nbu_pkg::OFF_MODE2, 32'h0);
        wr(nbu_pkg::OFF_SELCODE, 32'h15A);
        wr(nbu_pkg::OFF_MODE0, 32'h17);
        link_u.send(9'h077);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(nbu_pkg::OFF_CTRL, 32'h0);
        rd(nbu_pkg::OFF_ISTAT, 32'h0);
        for (int i = 0; i < 3; i++) begin
            link_u.send(fr[i]);
            wait_irq();
            rd(nbu_pkg::OFF_CTRL, {31'h0, fr[i][8]});
            rd(nbu_pkg::OFF_DATA, {24'h0, fr[i][7:0]});
            rd(nbu_pkg::OFF_ISTAT, 32'h1);
            rd(nbu_pkg::OFF_MODE0, mw[i]);
        end
        $display("wake-up test done");
    endtask : t_wake

    task automatic t_reply;
        wr(nbu_pkg::OFF_ODS, 32'h1);
        wr(nbu_pkg::OFF_DATA, 32'hC4);
        rd(nbu_pkg::OFF_CTRL, 32'h4);
        wait_got(3);
        chk({23'h0, link_u.got}, 32'h0C4);
        wait_irq();
        rd(nbu_pkg::OFF_ISTAT, 32'h2);
        $display("reply test done");
    endtask : t_reply

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // =====================================================================
    // clock, main sequence, watchdog
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_wake();
        t_reply();
        finish_test();
    end

    // the whole run needs well under a thousand cycles; this allows twenty thousand
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule : nbu_uart_tb

`default_nettype wire
